// ---- shared/ddc_pkg.sv ----
// Constants and carrier types for the descriptor-chaining sequencer.
// Assumes a single clock and a 16-bit word-addressed peripheral hub.
package ddc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int DESC_N = 16;
  localparam int IDX_W = 4;
  localparam int CNT_W = 8;
  localparam int MEM_AW = 6;
  localparam int WORDS_PER_DESC = 4;
  // Descriptor storage window in hub address space
  localparam logic [ADDR_W-MEM_AW-1:0] DESC_WIN = 10'h3FF;
  // Field offsets inside a descriptor
  localparam logic [1:0] OFS_SRC = 2'h0;
  localparam logic [1:0] OFS_DST = 2'h1;
  localparam logic [1:0] OFS_CNT = 2'h2;
  localparam logic [1:0] OFS_CTL = 2'h3;
  // Bit positions of the control word
  localparam int CTL_INC_SRC = 15;
  localparam int CTL_INC_DST = 14;
  localparam int CTL_END = 13;
  localparam logic [DATA_W-1:0] MEM_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ddc_hub_req_t;

  typedef struct packed {
    logic inc_src;
    logic inc_dst;
    logic last;
    logic [IDX_W-1:0] next;
    logic [CNT_W-1:0] count;
    logic [ADDR_W-1:0] dst;
    logic [ADDR_W-1:0] src;
  } ddc_desc_t;

  localparam ddc_hub_req_t HUB_IDLE = '{valid: 1'b0, write: 1'b0, addr: 16'h0000,
                                         wdata: 16'h0000};
endpackage : ddc_pkg

// ---- rtl/ddc_sequencer.sv ----
// Descriptor-chaining DMA sequencer with its own descriptor storage.
// Assumes the hub acks each request once, on the same clock, while valid.
// Contract
// R1 - A descriptor may chain to itself
// R2 - Two descriptors may chain to each other
// R3 - Last descriptor may chain back to first
// R4 - Each descriptor carries its own addresses
// R5 - Configuration, data, status descriptors run in order
// R6 - Subchains link into one longer chain
// R7 - Descriptor storage is reachable by transfers themselves
// R8 - Successor contents fetched fresh before starting
`timescale 1ns/10ps
`default_nettype none
module ddc_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [ddc_pkg::IDX_W-1:0] start_index,
  input wire logic stop,
  input wire logic cfg_we,
  input wire logic [ddc_pkg::MEM_AW-1:0] cfg_addr,
  input wire logic [ddc_pkg::DATA_W-1:0] cfg_wdata,
  output ddc_pkg::ddc_hub_req_t hub_req,
  input wire logic hub_ack,
  input wire logic [ddc_pkg::DATA_W-1:0] hub_rdata,
  output logic busy,
  output logic desc_done,
  output logic chain_done,
  output logic [ddc_pkg::IDX_W-1:0] cur_index
);
  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_RD, S_RD_WAIT, S_WR, S_WR_WAIT, S_NEXT
  } ddc_state_t;

  ddc_state_t state;
  logic [ddc_pkg::DATA_W-1:0] desc_mem [0:ddc_pkg::DESC_N*ddc_pkg::WORDS_PER_DESC-1];
  ddc_pkg::ddc_desc_t cur;
  logic [ddc_pkg::DATA_W-1:0] data;
  logic stop_req;
  ddc_pkg::ddc_desc_t fetched;
  logic chain_end;
  logic word_last;
  logic word_done;

  // Address falls inside the descriptor storage window
  function automatic logic in_win(input logic [ddc_pkg::ADDR_W-1:0] a);
    in_win = (a[ddc_pkg::ADDR_W-1:ddc_pkg::MEM_AW] == ddc_pkg::DESC_WIN);
  endfunction : in_win

  function automatic logic [ddc_pkg::MEM_AW-1:0] word_at(input logic [ddc_pkg::IDX_W-1:0] i,
                                                         input logic [1:0] ofs);
    word_at = {i, ofs};
  endfunction : word_at

  // Live storage read, so earlier nested writes are seen
  always_comb begin
    fetched.src = desc_mem[word_at(cur_index, ddc_pkg::OFS_SRC)]; // R8
    fetched.dst = desc_mem[word_at(cur_index, ddc_pkg::OFS_DST)];
    fetched.count = desc_mem[word_at(cur_index, ddc_pkg::OFS_CNT)][ddc_pkg::CNT_W-1:0];
    fetched.next = desc_mem[word_at(cur_index, ddc_pkg::OFS_CTL)][ddc_pkg::IDX_W-1:0];
    fetched.last = desc_mem[word_at(cur_index, ddc_pkg::OFS_CTL)][ddc_pkg::CTL_END];
    fetched.inc_dst = desc_mem[word_at(cur_index, ddc_pkg::OFS_CTL)][ddc_pkg::CTL_INC_DST];
    fetched.inc_src = desc_mem[word_at(cur_index, ddc_pkg::OFS_CTL)][ddc_pkg::CTL_INC_SRC];
  end

  // Engine writes win over setup writes; setup is meant for idle time only
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < ddc_pkg::DESC_N*ddc_pkg::WORDS_PER_DESC; k++) begin
        desc_mem[k] <= ddc_pkg::MEM_RESET;
      end
    end else if (state == S_WR && in_win(cur.dst)) begin
      desc_mem[cur.dst[ddc_pkg::MEM_AW-1:0]] <= data; // R7
    end else if (cfg_we) begin
      desc_mem[cfg_addr] <= cfg_wdata;
    end
  end

  // Stop request is sticky until the current descriptor finishes
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_req <= 1'b0;
    end else if (stop) begin
      stop_req <= 1'b1;
    end else if (state == S_IDLE || (state == S_NEXT)) begin
      stop_req <= 1'b0;
    end
  end

  // A stop seen at any time during a descriptor ends the chain after it
  assign chain_end = cur.last || stop_req || stop;
  assign word_last = (cur.count == 8'h01);
  assign word_done = (state == S_WR && in_win(cur.dst)) || (state == S_WR_WAIT && hub_ack);

  // Control sequence: fetch, then read and write each word, then chain
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          // A zero count moves no data but still chains
          if (fetched.count == ddc_pkg::CNT_RESET) begin
            state <= S_NEXT;
          end else begin
            state <= S_RD;
          end
        end
        S_RD: begin
          if (in_win(cur.src)) begin
            state <= S_WR;
          end else begin
            state <= S_RD_WAIT;
          end
        end
        S_RD_WAIT: begin
          if (hub_ack) begin
            state <= S_WR;
          end
        end
        S_WR: begin
          if (!in_win(cur.dst)) begin
            state <= S_WR_WAIT;
          end else if (word_last) begin
            state <= S_NEXT;
          end else begin
            state <= S_RD;
          end
        end
        S_WR_WAIT: begin
          if (hub_ack && word_last) begin
            state <= S_NEXT;
          end else if (hub_ack) begin
            state <= S_RD;
          end
        end
        S_NEXT: begin
          if (chain_end) begin
            state <= S_IDLE;
          end else begin
            state <= S_FETCH;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Working copy of the running descriptor; counts words and steps addresses
  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else if (state == S_FETCH) begin
      cur <= fetched; // R4 R8
    end else if (word_done) begin
      cur.count <= cur.count - 8'h01;
      if (cur.inc_src) begin
        cur.src <= cur.src + 16'h0001; // R4
      end
      if (cur.inc_dst) begin
        cur.dst <= cur.dst + 16'h0001;
      end
    end
  end

  // Successor may equal itself, a partner, or the chain head
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_index <= ddc_pkg::IDX_RESET;
    end else if (state == S_IDLE && start) begin
      cur_index <= start_index;
    end else if (state == S_NEXT && !chain_end) begin
      cur_index <= cur.next; // R1 R2 R3 R5 R6
    end
  end

  // Word in flight between its read and its write
  always_ff @(posedge clk) begin
    if (rst) begin
      data <= ddc_pkg::MEM_RESET;
    end else if (state == S_RD && in_win(cur.src)) begin
      data <= desc_mem[cur.src[ddc_pkg::MEM_AW-1:0]]; // R7
    end else if (state == S_RD_WAIT && hub_ack) begin
      data <= hub_rdata;
    end
  end

  // Request holds until its ack; storage window accesses never reach the hub
  always_ff @(posedge clk) begin
    if (rst) begin
      hub_req <= ddc_pkg::HUB_IDLE;
    end else if (state == S_RD && !in_win(cur.src)) begin
      hub_req <= '{valid: 1'b1, write: 1'b0, addr: cur.src, wdata: 16'h0000};
    end else if (state == S_WR && !in_win(cur.dst)) begin
      hub_req <= '{valid: 1'b1, write: 1'b1, addr: cur.dst, wdata: data};
    end else if ((state == S_RD_WAIT || state == S_WR_WAIT) && hub_ack) begin
      hub_req <= ddc_pkg::HUB_IDLE;
    end
  end

  // Busy rises at the start edge, before the fetch shows any activity
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != S_IDLE) || start;
    end
  end

  // One pulse per finished descriptor
  always_ff @(posedge clk) begin
    if (rst) begin
      desc_done <= 1'b0;
    end else begin
      desc_done <= (state == S_NEXT);
    end
  end

  // Coincides with the final descriptor pulse of a chain
  always_ff @(posedge clk) begin
    if (rst) begin
      chain_done <= 1'b0;
    end else begin
      chain_done <= (state == S_NEXT) && chain_end;
    end
  end
endmodule : ddc_sequencer
`default_nettype wire

// ---- bench/ddc_hub_model.sv ----
// Hub model: 256-word memory image, acks once per request.
// Assumes requests hold until acked; stall adds up to one cycle of answer delay.
`timescale 1ns/10ps
`default_nettype none
module ddc_hub_model (
  input wire logic clk,
  input wire logic stall,
  input wire ddc_pkg::ddc_hub_req_t req,
  output logic ack,
  output logic [15:0] rdata
);
  logic [15:0] mem [256];
  logic t = 1'b0;
  initial ack = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = {8'hA5, 8'(i)};
  // Released data shows the inverse, not a stale match
  assign rdata = ack ? mem[req.addr[7:0]] : ~mem[req.addr[7:0]];
  always @(posedge clk) begin
    t <= ~t;
    ack <= req.valid && !ack && (!stall || t);
    if (ack && req.write) mem[req.addr[7:0]] <= req.wdata;
  end
endmodule : ddc_hub_model
`default_nettype wire

// ---- bench/ddc_sequencer_chk.sv ----
// Checker for hub handshake and chain pulses.
// Assumes it is bound onto the sequencer ports.
`timescale 1ns/10ps
`default_nettype none
module ddc_sequencer_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic busy,
  input wire ddc_pkg::ddc_hub_req_t hub_req,
  input wire logic hub_ack,
  input wire logic [15:0] hub_rdata,
  input wire logic desc_done,
  input wire logic chain_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  win_blocked_a: assert property (hub_req.valid |-> hub_req.addr[15:6] != ddc_pkg::DESC_WIN)
    else $error("storage access on hub");
  req_hold_a: assert property (hub_req.valid && !hub_ack |=> $stable(hub_req))
    else $error("request moved");
  ack_drop_a: assert property (hub_ack |=> !hub_req.valid)
    else $error("request after ack");
  rd_then_wr_a: assert property (hub_ack && !hub_req.write |->
    ##2 (!hub_req.valid || hub_req.write))
    else $error("read followed by read");
  data_pass_a: assert property ((hub_ack && !hub_req.write) ##2 hub_req.valid |->
    hub_req.write && hub_req.wdata == $past(hub_rdata, 2))
    else $error("write data differs");
  start_take_a: assert property (start && !busy |=> busy)
    else $error("start not taken");
  end_pair_a: assert property (chain_done |-> desc_done && busy)
    else $error("chain end unpaired");
  idle_quiet_a: assert property (!busy |-> !hub_req.valid)
    else $error("request while idle");
  cover property (chain_done);
  cover property (desc_done && !chain_done);
  cover property (hub_ack && hub_req.write);
endmodule : ddc_sequencer_chk
bind ddc_sequencer ddc_sequencer_chk i_chk (.clk(clk), .rst(rst), .start(start), .busy(busy),
  .hub_req(hub_req), .hub_ack(hub_ack), .hub_rdata(hub_rdata), .desc_done(desc_done),
  .chain_done(chain_done));
`default_nettype wire

// ---- bench/tb_top.sv ----
// Testbench: descriptor chains run against the hub memory model.
// Assumes memory word a starts as A5 followed by a[7:0].
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk = 0, rst = 1, start = 0, stop = 0, cfg_we = 0, stall = 0;
  logic [3:0] start_index = 0, cur_index;
  logic [5:0] cfg_addr = 0;
  logic [15:0] cfg_wdata = 0, hub_rdata;
  logic hub_ack, busy, desc_done, chain_done;
  ddc_pkg::ddc_hub_req_t hub_req;
  int errors = 0, num_checks = 0, cyc = 0;
  ddc_sequencer i_ddc_sequencer (.clk(clk), .rst(rst), .start(start), .start_index(start_index),
    .stop(stop), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .hub_req(hub_req),
    .hub_ack(hub_ack), .hub_rdata(hub_rdata), .busy(busy), .desc_done(desc_done),
    .chain_done(chain_done), .cur_index(cur_index));
  ddc_hub_model i_ddc_hub_model (.clk(clk), .stall(stall), .req(hub_req), .ack(hub_ack),
    .rdata(hub_rdata));
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (++cyc == 5000) begin errors++; tally_and_finish(); end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic desc(input int d, input logic [15:0] s, t, c, k);
    logic [15:0] w [4];
    w = '{s, t, c, k};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cfg_we <= 1'b1;
      cfg_addr <= {4'(d), 2'(i)};
      cfg_wdata <= w[i];
    end
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask : desc
  task automatic go(input int d, input bit wt);
    @(posedge clk);
    start <= 1'b1;
    start_index <= 4'(d);
    @(posedge clk);
    start <= 1'b0;
    // Bounded so a lost chain end cannot hang the run
    for (int i = 0; i < 400 && wt && chain_done !== 1'b1; i++) @(posedge clk);
    if (wt) begin
      `CHK("chain_done", 1'b1, chain_done)
      `CHK("desc_done", 1'b1, desc_done)
      @(posedge clk);
      `CHK("busy", 1'b0, busy)
    end
  endtask : go
  task automatic ring(input int f, n);
    for (int j = 0; j < n; j++) desc(f + j, 16'h0040, 16'h00A0, 16'h0001, 16'(f + (j + 1) % n));
    go(f, 0);
    for (int k = 0; k < 2 * n; k++) begin
      for (int i = 0; i < 99 && !(hub_ack === 1'b1 && hub_req.write === 1'b1); i++) @(posedge clk);
      `CHK("write ack", 1'b1, hub_ack && hub_req.write)
      `CHK("cur_index", 4'(f + k % n), cur_index)
      @(posedge clk);
    end
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    for (int i = 0; i < 200 && chain_done !== 1'b1; i++) @(posedge clk);
    `CHK("ring end", 1'b1, chain_done)
  endtask : ring
  task automatic packet();
    desc(0, 16'h0010, 16'h0080, 16'h0001, 16'h0001);
    desc(1, 16'h0020, 16'h0081, 16'h0002, 16'hC002);
    desc(2, 16'h0090, 16'h0030, 16'h0001, 16'h2000);
    go(0, 1);
    `CHK("config", 16'hA510, i_ddc_hub_model.mem[8'h80])
    `CHK("data0", 16'hA520, i_ddc_hub_model.mem[8'h81])
    `CHK("data1", 16'hA521, i_ddc_hub_model.mem[8'h82])
    `CHK("status", 16'hA590, i_ddc_hub_model.mem[8'h30])
  endtask : packet
  task automatic storage_src();
    desc(10, 16'hFFE9, 16'h00B0, 16'h0001, 16'h2000);
    desc(11, 16'h0040, 16'h00B1, 16'h0000, 16'h000A);
    go(11, 1);
    `CHK("from storage", 16'h00B0, i_ddc_hub_model.mem[8'hB0])
    `CHK("zero count", 16'hA5B1, i_ddc_hub_model.mem[8'hB1])
  endtask : storage_src
  task automatic nested();
    i_ddc_hub_model.mem[8'h50] = 16'h0033;
    desc(8, 16'h0050, 16'hFFE4, 16'h0001, 16'h0009);
    desc(9, 16'h0060, 16'h0070, 16'h0001, 16'h2000);
    stall <= 1'b1;
    go(8, 1);
    `CHK("nested", 16'hA533, i_ddc_hub_model.mem[8'h70])
  endtask : nested
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    packet();
    ring(3, 1);
    ring(4, 2);
    ring(6, 3);
    storage_src();
    nested();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
